// File: scsd_cfg.svh
// Constants for the system clock select and divide block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SCSD_CFG_SVH
`define SCSD_CFG_SVH

// ---------------------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ---------------------------------------------------------------------------
`define SCSD_ADDR_W          8
`define SCSD_OFF_CTRL_ZERO   8'h00
`define SCSD_OFF_CTRL_TWO    8'h04
`define SCSD_OFF_STATUS      8'h08

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define SCSD_XTAL_BIT        7
`define SCSD_SLEEP_HI        4
`define SCSD_SLEEP_LO        3
`define SCSD_SPEED_HI        2
`define SCSD_SPEED_LO        0
`define SCSD_EXTSEL_BIT      2
`define SCSD_SLEEP_RST       2'h0
`define SCSD_SPEED_RST       3'h2
`define SCSD_EXTSEL_RST      1'b0

// ---------------------------------------------------------------------------
// Processor clock ratios, as half-period counts of system clock rises
// ---------------------------------------------------------------------------
`define SCSD_SPEED_DIV1      3'h3
`define SCSD_HALF_SPD0       8'h04
`define SCSD_HALF_SPD1       8'h02
`define SCSD_HALF_SPD2       8'h01
`define SCSD_HALF_SPD4       8'h08
`define SCSD_HALF_SPD5       8'h10
`define SCSD_HALF_SPD6       8'h40
`define SCSD_HALF_SPD7       8'h80

// ---------------------------------------------------------------------------
// Sleep interval lengths in slow oscillator clocks, less one
// ---------------------------------------------------------------------------
`define SCSD_SLP_CNT_W       15
`define SCSD_SLP_LAST0       15'h003F
`define SCSD_SLP_LAST1       15'h01FF
`define SCSD_SLP_LAST2       15'h0FFF
`define SCSD_SLP_LAST3       15'h7FFF
`define SCSD_SLP_ONE         15'h0001

// ---------------------------------------------------------------------------
// Switch sequencing
// ---------------------------------------------------------------------------
`define SCSD_SYNC_STAGES     2'h2
`define SCSD_ASYNC_W         4

`endif

// File: scsd_pkg.sv
// Types shared by the system clock select and divide block.
// Assumes scsd_cfg.svh is reachable on the include path.
package scsd_pkg;
  `include "scsd_cfg.svh"

  typedef enum logic [1:0] {
    SCSD_RUN      = 2'b00,
    SCSD_GATE_OFF = 2'b01,
    SCSD_SYNC_NEW = 2'b10,
    SCSD_ARM_NEW  = 2'b11
  } scsd_state_t;

  typedef logic [`SCSD_ADDR_W-1:0] scsd_addr_t;
endpackage

// File: scsd_clock_select.sv
// System clock select, glitch-free switch, processor divider, sleep timer.
// Assumes an APB master on mclk; oscillator and pin clocks arrive as
// asynchronous levels far slower than mclk and are sampled here.
//
// Behaviour
// - Processor clock is system clock divided by one of eight ratios.
// - System clock net carries main oscillator or external pin clock directly.
// - Four sleep intervals selectable, about 1.95 ms up to 1 second.
// - Main oscillator drives system clock net by default, nominal 12 MHz.
// - Asynchronous inputs and slow oscillator resynchronised before use.
// - Slow oscillator clocks sleep and watchdog timing, also exported.
// - Slow oscillator may stop in deep sleep, or sleep with crystal on.
// - External select bit resets to zero; boot always from main oscillator.
// - With select set, system clock and slow signals follow external clock.
// - Divider two or more: old gate drops after next falling edge.
// - New gate enable double synchronised, opens on following falling edge.
// - Divider one: select applied on falling edge, gate drops at once.
// - Source change accepted any time, completed without disturbance.
// - Sleep field 00..11 selects 64, 512, 4096, 32768 slow clocks.
// - Processor speed field resets to 010b, half the system clock.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps

module scsd_clock_select (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire scsd_pkg::scsd_addr_t    paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    main_osc_clock,
  input  wire logic                    ext_clock_in,
  input  wire logic                    slow_osc_clock,
  input  wire logic [`SCSD_ASYNC_W-1:0] async_in,
  input  wire logic                    sleep_active,
  input  wire logic                    deep_sleep,
  output logic                         system_clock_net,
  output logic                         processor_clock,
  output logic                         slow_clock_sync,
  output logic [`SCSD_ASYNC_W-1:0]     async_sync,
  output logic                         sleep_tick,
  output logic                         slow_osc_enable,
  output logic                         crystal_osc_32k_en
);
  import scsd_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [`SCSD_ASYNC_W+2:0] pin_s1_q;
  logic [`SCSD_ASYNC_W+2:0] pin_s2_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {async_in, slow_osc_clock, ext_clock_in, main_osc_clock};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic main_lvl;
  logic ext_lvl;
  logic slow_lvl;
  assign main_lvl = pin_s2_q[0];
  assign ext_lvl  = pin_s2_q[1];
  assign slow_lvl = pin_s2_q[2];

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic       xtal_on_q;
  logic [1:0] sleep_sel_q;
  logic [2:0] speed_q;
  logic       ext_sel_q;
  logic       pready_q;
  logic [31:0] prdata_q;
  logic       pslverr_q;
  logic       wr_take;
  logic       mapped;

  assign mapped  = (paddr == `SCSD_OFF_CTRL_ZERO) || (paddr == `SCSD_OFF_CTRL_TWO) ||
                   (paddr == `SCSD_OFF_STATUS);
  assign wr_take = psel && penable && pready_q && pwrite;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xtal_on_q   <= 1'b0;
      sleep_sel_q <= `SCSD_SLEEP_RST;
      speed_q     <= `SCSD_SPEED_RST;
      ext_sel_q   <= `SCSD_EXTSEL_RST;
    end else if (wr_take) begin
      if (paddr == `SCSD_OFF_CTRL_ZERO) begin
        xtal_on_q   <= pwdata[`SCSD_XTAL_BIT];
        sleep_sel_q <= pwdata[`SCSD_SLEEP_HI:`SCSD_SLEEP_LO];
        speed_q     <= pwdata[`SCSD_SPEED_HI:`SCSD_SPEED_LO];
      end else if (paddr == `SCSD_OFF_CTRL_TWO) begin
        ext_sel_q   <= pwdata[`SCSD_EXTSEL_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Switch sequencer
  // ---------------------------------------------------------------------------
  scsd_state_t state_q;
  logic        sel_applied_q;
  logic        cur_ext_q;
  logic        gate_main_q;
  logic        gate_ext_q;
  logic [1:0]  sync_cnt_q;
  logic        new_prev_q;
  logic        cur_lvl;
  logic        new_lvl;
  logic        sys_d;
  logic        sys_q;

  assign cur_lvl = cur_ext_q ? ext_lvl : main_lvl;
  assign new_lvl = cur_ext_q ? main_lvl : ext_lvl;

  // Divide by one: select lands only while the net is low, as with a falling-edge write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_applied_q <= `SCSD_EXTSEL_RST;
    end else if (speed_q != `SCSD_SPEED_DIV1) begin
      sel_applied_q <= ext_sel_q;
    end else if (!sys_q) begin
      sel_applied_q <= ext_sel_q;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q     <= SCSD_RUN;
      cur_ext_q   <= 1'b0;
      gate_main_q <= 1'b1;
      gate_ext_q  <= 1'b0;
      sync_cnt_q  <= 2'h0;
      new_prev_q  <= 1'b0;
    end else begin
      new_prev_q <= new_lvl;
      case (state_q)
        SCSD_RUN: begin
          if (sel_applied_q != cur_ext_q) begin
            state_q <= SCSD_GATE_OFF;
          end
        end
        SCSD_GATE_OFF: begin
          // Only cut while low, so the net never shows a runt high
          if (!cur_lvl) begin
            gate_main_q <= 1'b0;
            gate_ext_q  <= 1'b0;
            sync_cnt_q  <= 2'h0;
            state_q     <= SCSD_SYNC_NEW;
          end
        end
        SCSD_SYNC_NEW: begin
          if (new_lvl && !new_prev_q) begin
            sync_cnt_q <= sync_cnt_q + 2'h1;
            if (sync_cnt_q + 2'h1 == `SCSD_SYNC_STAGES) begin
              state_q <= SCSD_ARM_NEW;
            end
          end
        end
        SCSD_ARM_NEW: begin
          if (!new_lvl && new_prev_q) begin
            cur_ext_q   <= !cur_ext_q;
            gate_main_q <= cur_ext_q;
            gate_ext_q  <= !cur_ext_q;
            sync_cnt_q  <= 2'h0;
            state_q     <= SCSD_RUN;
          end
        end
        default: state_q <= SCSD_RUN;
      endcase
    end
  end

  assign sys_d = (main_lvl && gate_main_q) || (ext_lvl && gate_ext_q);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys_q <= 1'b0;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign system_clock_net = sys_q;

  // ---------------------------------------------------------------------------
  // Processor clock divider
  // ---------------------------------------------------------------------------
  logic       sys_rise;
  logic       sys_prev_q;
  logic [7:0] half_cnt;
  logic [7:0] div_cnt_q;
  logic       div_clk_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys_prev_q <= 1'b0;
    end else begin
      sys_prev_q <= sys_q;
    end
  end

  assign sys_rise = sys_q && !sys_prev_q;

  always_comb begin
    case (speed_q)
      3'h0:    half_cnt = `SCSD_HALF_SPD0;
      3'h1:    half_cnt = `SCSD_HALF_SPD1;
      3'h2:    half_cnt = `SCSD_HALF_SPD2;
      3'h4:    half_cnt = `SCSD_HALF_SPD4;
      3'h5:    half_cnt = `SCSD_HALF_SPD5;
      3'h6:    half_cnt = `SCSD_HALF_SPD6;
      3'h7:    half_cnt = `SCSD_HALF_SPD7;
      default: half_cnt = 8'h01;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 8'h00;
      div_clk_q <= 1'b0;
    end else if (sys_rise) begin
      if (div_cnt_q + 8'h01 >= half_cnt) begin
        div_cnt_q <= 8'h00;
        div_clk_q <= !div_clk_q;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end

  // Divide by one passes the net itself; the toggle path would halve it
  assign processor_clock = (speed_q == `SCSD_SPEED_DIV1) ? sys_q : div_clk_q;

  // ---------------------------------------------------------------------------
  // Slow clock, async inputs and sleep timer
  // ---------------------------------------------------------------------------
  logic                       slow_cap_q;
  logic                       slow_prev_q;
  logic [`SCSD_ASYNC_W-1:0]   async_cap_q;
  logic [`SCSD_SLP_CNT_W-1:0] slp_cnt_q;
  logic [`SCSD_SLP_CNT_W-1:0] slp_last;
  logic                       tick_q;

  // Captured on system clock rises so consumers see the selected source's timing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slow_cap_q  <= 1'b0;
      slow_prev_q <= 1'b0;
      async_cap_q <= '0;
    end else if (sys_rise) begin
      slow_cap_q  <= slow_lvl;
      slow_prev_q <= slow_cap_q;
      async_cap_q <= pin_s2_q[`SCSD_ASYNC_W+2:3];
    end
  end

  always_comb begin
    case (sleep_sel_q)
      2'h0:    slp_last = `SCSD_SLP_LAST0;
      2'h1:    slp_last = `SCSD_SLP_LAST1;
      2'h2:    slp_last = `SCSD_SLP_LAST2;
      default: slp_last = `SCSD_SLP_LAST3;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slp_cnt_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (sys_rise && slow_cap_q && !slow_prev_q) begin
        if (slp_cnt_q >= slp_last) begin
          slp_cnt_q <= '0;
          tick_q    <= 1'b1;
        end else begin
          slp_cnt_q <= slp_cnt_q + `SCSD_SLP_ONE;
        end
      end
    end
  end

  assign slow_clock_sync    = slow_cap_q;
  assign async_sync         = async_cap_q;
  assign sleep_tick         = tick_q;
  assign crystal_osc_32k_en = xtal_on_q;
  assign slow_osc_enable    = !(deep_sleep || (sleep_active && xtal_on_q));

  // ---------------------------------------------------------------------------
  // APB slave, one wait state
  // ---------------------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr == `SCSD_OFF_CTRL_ZERO) begin
      rd_word[`SCSD_XTAL_BIT]                 = xtal_on_q;
      rd_word[`SCSD_SLEEP_HI:`SCSD_SLEEP_LO] = sleep_sel_q;
      rd_word[`SCSD_SPEED_HI:`SCSD_SPEED_LO] = speed_q;
    end else if (paddr == `SCSD_OFF_CTRL_TWO) begin
      rd_word[`SCSD_EXTSEL_BIT] = ext_sel_q;
    end else if (paddr == `SCSD_OFF_STATUS) begin
      rd_word[4:0] = {state_q != SCSD_RUN, state_q == SCSD_SYNC_NEW || state_q == SCSD_ARM_NEW,
                      gate_ext_q, gate_main_q, cur_ext_q};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q  <= 1'b1;
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_q <= !mapped;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
endmodule

// File: scsd_src_model.sv
// Far-side clock sources: main oscillator, external clock pin, slow oscillator.
// Assumes mclk at 50 ns; every source is far slower than mclk so sampling sees it.
`timescale 1ns/100ps
module scsd_src_model #(
  parameter int MAIN_HALF = 200,
  parameter int EXT_HALF  = 300,
  parameter int SLOW_HALF = 600
) (
  output logic main_osc_clock,
  output logic ext_clock_in,
  output logic slow_osc_clock
);
  // Odd start offsets keep source edges off mclk edges
  initial begin
    main_osc_clock = 1'b0;
    #7 forever #(MAIN_HALF) main_osc_clock = ~main_osc_clock;
  end
  // Clean digital edges, never floating, 1.67 MHz, free running
  initial begin
    ext_clock_in = 1'b0;
    #13 forever #(EXT_HALF) ext_clock_in = ~ext_clock_in;
  end
  initial begin
    slow_osc_clock = 1'b0;
    #19 forever #(SLOW_HALF) slow_osc_clock = ~slow_osc_clock;
  end
endmodule

// File: scsd_chk.sv
// Port checker for the clock select block, bound to every instance.
// Assumes one mclk domain and rst asynchronous, active high.
`timescale 1ns/100ps
`include "scsd_cfg.svh"
module scsd_chk (
  input wire logic                     mclk,
  input wire logic                     rst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire scsd_pkg::scsd_addr_t     paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     main_osc_clock,
  input wire logic                     ext_clock_in,
  input wire logic                     slow_osc_clock,
  input wire logic [`SCSD_ASYNC_W-1:0] async_in,
  input wire logic                     sleep_active,
  input wire logic                     deep_sleep,
  input wire logic                     system_clock_net,
  input wire logic                     processor_clock,
  input wire logic                     slow_clock_sync,
  input wire logic [`SCSD_ASYNC_W-1:0] async_sync,
  input wire logic                     sleep_tick,
  input wire logic                     slow_osc_enable,
  input wire logic                     crystal_osc_32k_en
);
  import scsd_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  refuse_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error response malformed");
  reset_quiet_a: assert property ($fell(rst) |-> !system_clock_net && !processor_clock && !sleep_tick)
    else $error("outputs not quiet after reset");
  deep_stop_a: assert property (deep_sleep || (sleep_active && crystal_osc_32k_en) |-> !slow_osc_enable)
    else $error("slow oscillator left on");
  awake_osc_a: assert property (!deep_sleep && !sleep_active |-> slow_osc_enable)
    else $error("slow oscillator off while awake");
  tick_single_a: assert property (sleep_tick |=> !sleep_tick [*8])
    else $error("sleep tick too long or too close");
  slow_sync_a: assert property ($changed(slow_clock_sync) |-> ##[0:1] (system_clock_net || $past(system_clock_net)))
    else $error("slow clock captured off a system clock rise");
  async_sync_a: assert property ($changed(async_sync) |-> ##[0:1] (system_clock_net || $past(system_clock_net)))
    else $error("async input captured off a system clock rise");
endmodule

bind scsd_clock_select scsd_chk scsd_chk_inst (
  .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .main_osc_clock,
  .ext_clock_in, .slow_osc_clock, .async_in, .sleep_active, .deep_sleep, .system_clock_net,
  .processor_clock, .slow_clock_sync, .async_sync, .sleep_tick, .slow_osc_enable, .crystal_osc_32k_en
);

// File: scsd_clock_select_tb.sv
// Self-checking bench: registers, divider ratios, sleep ticks, power, source switch.
// Assumes the source model runs main at 8, external at 12, slow at 24 mclk periods.
`timescale 1ns/100ps
`include "scsd_cfg.svh"
module scsd_clock_select_tb;
  import scsd_pkg::*;
  localparam scsd_addr_t    C0 = `SCSD_OFF_CTRL_ZERO;
  localparam scsd_addr_t    C2 = `SCSD_OFF_CTRL_TWO;
  localparam scsd_addr_t    ST = `SCSD_OFF_STATUS;
  logic                     mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic                     main_osc_clock, ext_clock_in, slow_osc_clock, sleep_active, deep_sleep;
  logic                     system_clock_net, processor_clock, slow_clock_sync, sleep_tick;
  logic                     slow_osc_enable, crystal_osc_32k_en;
  scsd_addr_t               paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [`SCSD_ASYNC_W-1:0] async_in, async_sync;
  int                       miscompares, compares, n;
  int                       ratios [8] = '{8, 4, 2, 1, 16, 32, 128, 256};

  scsd_src_model scsd_src_model_inst (.main_osc_clock, .ext_clock_in, .slow_osc_clock);
  scsd_clock_select scsd_clock_select_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_osc_clock, .ext_clock_in, .slow_osc_clock, .async_in, .sleep_active, .deep_sleep,
    .system_clock_net, .processor_clock, .slow_clock_sync, .async_sync, .sleep_tick, .slow_osc_enable,
    .crystal_osc_32k_en);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input scsd_addr_t a, input logic w, input logic [31:0] wd);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) miscompares++;
  endtask

  task automatic rd_chk(input scsd_addr_t a, input logic [31:0] exp, input logic eerr);
    apb(a, 1'b0, 32'h0);
    check("read data", exp, rd);
    check("slave error", 32'(eerr), 32'(err));
  endtask

  // Mode 0: system rises per processor period; 1: slow rises per tick; 2: mclk per system period.
  // The first interval is skipped in mode 0 since a ratio change may leave it partial.
  task automatic count_between(input int sel, output int cnt);
    logic a, b, ap, bp;
    int   p, first;
    p = 0;
    cnt = 0;
    ap = 1'b1;
    bp = 1'b1;
    first = (sel == 0) ? 2 : 1;
    repeat (30000) begin
      @(posedge mclk);
      a = (sel == 1) ? slow_osc_clock : system_clock_net;
      b = (sel == 0) ? processor_clock : (sel == 1) ? sleep_tick : system_clock_net;
      if (p == first && (sel == 2 || (a && !ap))) cnt++;
      if (b && !bp) p++;
      ap = a;
      bp = b;
      if (p == first + 1) break;
    end
  endtask

  task automatic wait_switch(input logic ext);
    int k;
    k = 0;
    do begin
      apb(ST, 1'b0, 32'h0);
      check("gate overlap", 32'h0, 32'(rd[1] & rd[2]));
      k++;
    end while ((rd[0] !== ext || rd[4] !== 1'b0) && k < 100);
    check("switch status", ext ? 32'h05 : 32'h02, rd);
  endtask

  task automatic reset_regs;
    check("crystal enable", 32'h0, 32'(crystal_osc_32k_en));
    rd_chk(C0, 32'h02, 1'b0);
    rd_chk(C2, 32'h0, 1'b0);
    rd_chk(ST, 32'h02, 1'b0);
    apb(ST, 1'b1, 32'h1F);
    rd_chk(ST, 32'h02, 1'b0);
    rd_chk(8'h0C, 32'h0, 1'b1);
  endtask

  task automatic speed_ratios;
    count_between(0, n);
    check("reset ratio", 32'h2, 32'(n));
    for (int s = 0; s < 8; s++) begin
      apb(C0, 1'b1, 32'(s));
      count_between(0, n);
      check("cpu ratio", 32'(ratios[s]), 32'(n));
    end
  endtask

  task automatic sleep_periods;
    for (int f = 0; f < 2; f++) begin
      apb(C0, 1'b1, 32'(f << 3) | 32'h2);
      count_between(1, n);
      check("sleep clocks", 32'(64 << (3 * f)), 32'(n));
    end
    apb(C0, 1'b1, 32'h1A);
    rd_chk(C0, 32'h1A, 1'b0);
  endtask

  task automatic sync_and_power;
    async_in <= 4'hA;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (async_sync !== 4'hA && n < 200);
    check("async sync", 32'hA, 32'(async_sync));
    for (int v = 1; v >= 0; v--) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (slow_clock_sync !== 1'(v) && n < 100);
      check("slow clock sync", 32'(v), 32'(slow_clock_sync));
    end
    apb(C0, 1'b1, 32'h9A);
    // Main oscillator still selected before low power
    sleep_active <= 1'b1;
    @(posedge mclk);
    check("crystal enable", 32'h1, 32'(crystal_osc_32k_en));
    check("slow osc enable", 32'h0, 32'(slow_osc_enable));
    sleep_active <= 1'b0;
    @(posedge mclk);
    check("slow osc enable", 32'h1, 32'(slow_osc_enable));
    deep_sleep <= 1'b1;
    @(posedge mclk);
    check("slow osc enable", 32'h0, 32'(slow_osc_enable));
    deep_sleep <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic source_switch;
    apb(C2, 1'b1, 32'h04);
    wait_switch(1'b1);
    count_between(2, n);
    check("ext period", 32'hC, 32'(n));
    apb(C0, 1'b1, 32'h3);
    apb(C2, 1'b1, 32'h0);
    wait_switch(1'b0);
    count_between(2, n);
    check("main period", 32'h8, 32'(n));
    apb(C2, 1'b1, 32'h04);
    apb(C2, 1'b1, 32'h0);
    wait_switch(1'b0);
    count_between(2, n);
    check("main period", 32'h8, 32'(n));
  endtask

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    async_in = '0;
    sleep_active = 1'b0;
    deep_sleep = 1'b0;
    miscompares = 0;
    compares = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    reset_regs();
    speed_ratios();
    sleep_periods();
    sync_and_power();
    source_switch();
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    finish_test();
  end
endmodule
